// File: verilog/ddchp_device.sv
// ddchp_device: device end of the host port, serial clocking and sync
// assumes: all pins asynchronous; REF_CLK is the processing clock;
// sample clock and timing reference arrive as pins and are sampled.
// Operation
// [R1] serial bit clock divides processing clock, set ratio
// [R2] serial disable high floats serial pins
// [R3] data bus eight bits, bit 7 msb
// [R4] address bus three bits, bit 2 msb
// [R5] write rising edge stores byte at address
// [R6] read falling edge drives selected location
// [R7] reference clock at most half processing clock
// [R8] timing error measured against reference clock
// [R9] chip sync out hands front to back
// [R10] chip sync in tied to one sync out
// [R11] front sync drives cic and nco as selected
// [R12] back sync drives fir, timing, agc enables
// [R13] host triggered sync strobe, selectable clock source
// [R14] front sections run on sample clock edge
// [R15] back sections run on processing clock edge
// [R16] all three clocks may be asynchronous
// [R17] frame strobe marks serial data words
// [R18] sample and processing clocks always present
// [R19] host words cross domains without tearing
`timescale 1ns/10ps
module ddchp_device (
  input  wire logic REF_CLK,
  input  wire logic SYS_RST,
  input  wire logic CLK_EN,
  ddchp_if.device   BUS,
  input  wire logic FRONTEND_SAMPLE_CLOCK,
  input  wire logic TIMING_REFERENCE_CLOCK,
  input  wire logic CHIP_SYNC_IN,
  output logic      CHIP_SYNC_OUT,
  output logic      CIC_SYNC,
  output logic      CARRIER_NCO_SYNC,
  output logic      FIR_SYNC,
  output logic      TIMING_NCO_SYNC,
  output logic      AGC_SYNC
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] strb_s;
  logic [7:0] data_s;
  logic [2:0] addr_s;
  logic [5:0] misc_s;
  // strobes, data and address pass two flops before use [R19]
  // strobes synchronised active high, so the flops' reset level matches the idle pins
  ddchp_sync2 #(.W(3)) u_strb (.clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN),
    .d({~BUS.wr_n, ~BUS.rd_n, BUS.serial_output_disable}), .q(strb_s));
  ddchp_sync2 #(.W(8)) u_data (.clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN),
    .d(BUS.host_data_to_dev), .q(data_s));
  ddchp_sync2 #(.W(3)) u_addr (.clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN), .d(BUS.addr), .q(addr_s));
  // clocks sampled as levels since every clock may be unrelated [R16]
  ddchp_sync2 #(.W(6)) u_misc (.clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN),
    .d({FRONTEND_SAMPLE_CLOCK, TIMING_REFERENCE_CLOCK, CHIP_SYNC_IN, BUS.front_sync_in,
        BUS.back_sync_in, 1'b0}), .q(misc_s));
  wire wr_s     = strb_s[2];  // write strobe asserted
  wire rd_s     = strb_s[1];  // read strobe asserted
  wire ser_dis  = strb_s[0];
  wire fclk_s   = misc_s[5];
  wire rclk_s   = misc_s[4];
  wire msync_s  = misc_s[3];
  wire fsync_s  = misc_s[2];
  wire bsync_s  = misc_s[1];
  // ---------------------------------------------------------------
  // edge detection on synchronised strobes and sample and reference clocks
  // ---------------------------------------------------------------
  logic wr_d_ff;
  logic rd_d_ff;
  logic fclk_d_ff;
  logic rclk_d_ff;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_d_ff   <= 1'b0;
      rd_d_ff   <= 1'b0;
      fclk_d_ff <= 1'b0;
      rclk_d_ff <= 1'b0;
    end else if (CLK_EN) begin
      wr_d_ff   <= wr_s;
      rd_d_ff   <= rd_s;
      fclk_d_ff <= fclk_s;
      rclk_d_ff <= rclk_s;
    end
  end
  wire wr_rise   = ~wr_s & wr_d_ff;  // [R5] pin rises as the asserted strobe ends
  wire rd_fall   = rd_s & ~rd_d_ff;  // [R6]
  wire fclk_rise = fclk_s & ~fclk_d_ff;  // [R14]
  wire rclk_rise = rclk_s & ~rclk_d_ff;  // [R8]
  // ---------------------------------------------------------------
  // control words
  // ---------------------------------------------------------------
  logic [7:0] cw_ff [8];
  // whole byte lands at once after both data and strobe settled [R5] [R19]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < 8; i++) cw_ff[i] <= ddchp_pkg::RST_CW;
      cw_ff[ddchp_pkg::CW_SER_DIV] <= ddchp_pkg::RST_DIV;
    end else if (CLK_EN && wr_rise) begin
      cw_ff[addr_s] <= data_s;
    end
  end
  wire [7:0] sel_w    = cw_ff[ddchp_pkg::CW_SYNC_SEL];
  wire [7:0] div_w    = cw_ff[ddchp_pkg::CW_SER_DIV];
  wire       sync_cmd = wr_rise & (addr_s == ddchp_pkg::CW_SYNC_CMD);
  // ---------------------------------------------------------------
  // front/back handoff sync and section sync outputs
  // ---------------------------------------------------------------
  logic msync_tgl_ff;
  logic [1:0] fsync_ff;
  logic [2:0] bsync_ff;
  logic [7:0] sync_cnt_ff;
  // chip sync out toggles per front sample; handoff is taken from chip sync in [R9] [R10]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      msync_tgl_ff <= 1'b0;
      fsync_ff     <= 2'b00;
      bsync_ff     <= 3'b000;
      sync_cnt_ff  <= 8'h00;
    end else if (CLK_EN) begin
      if (fclk_rise) msync_tgl_ff <= ~msync_tgl_ff;                           // [R9]
      fsync_ff <= {2{fsync_s & msync_s}} &
                  {sel_w[ddchp_pkg::SEL_NCO_BIT], sel_w[ddchp_pkg::SEL_CIC_BIT]}; // [R11]
      bsync_ff <= {3{bsync_s}} & {cw_ff[ddchp_pkg::CW_BACK_EN_A][ddchp_pkg::EN_BIT],
                  cw_ff[ddchp_pkg::CW_BACK_EN_B][ddchp_pkg::EN_BIT],
                  cw_ff[ddchp_pkg::CW_BACK_EN_C][ddchp_pkg::EN_BIT]};           // [R12] [R15]
      if (bsync_s | fsync_s) sync_cnt_ff <= sync_cnt_ff + 8'h01;
    end
  end
  assign CHIP_SYNC_OUT    = msync_tgl_ff;
  assign CIC_SYNC         = fsync_ff[0];
  assign CARRIER_NCO_SYNC = fsync_ff[1];
  assign FIR_SYNC         = bsync_ff[2];
  assign TIMING_NCO_SYNC  = bsync_ff[1];
  assign AGC_SYNC         = bsync_ff[0];
  // ---------------------------------------------------------------
  // sync strobe out: processing clock or aligned to sample edge
  // ---------------------------------------------------------------
  logic pend_ff;
  logic strobe_ff;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_ff   <= 1'b0;
      strobe_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (sel_w[ddchp_pkg::SEL_SRC_BIT]) begin
        // waits for next sample edge, so latency varies by one sample [R13]
        strobe_ff <= (pend_ff | sync_cmd) & fclk_rise;
        pend_ff   <= (pend_ff | sync_cmd) & ~fclk_rise;
      end else begin
        strobe_ff <= sync_cmd;  // [R13]
        pend_ff   <= 1'b0;
      end
    end
  end
  assign BUS.sync_strobe_out = strobe_ff;
  // ---------------------------------------------------------------
  // timing error: processing cycles between reference edges
  // ---------------------------------------------------------------
  logic [7:0] te_cnt_ff;
  logic [7:0] te_ff;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      te_cnt_ff <= 8'h00;
      te_ff     <= 8'h00;
    end else if (CLK_EN) begin
      if (rclk_rise) begin  // [R8]
        te_ff     <= te_cnt_ff;
        te_cnt_ff <= 8'h00;
      end else begin
        te_cnt_ff <= te_cnt_ff + 8'h01;
      end
    end
  end
  // ---------------------------------------------------------------
  // host read path
  // ---------------------------------------------------------------
  logic [7:0] rdata_ff;
  logic       rd_oe_ff;
  wire  [7:0] rd_mux = (addr_s == ddchp_pkg::RD_STATUS)     ? {5'h00, pend_ff, ser_dis, msync_s} :
                       (addr_s == ddchp_pkg::RD_TIMING_ERR) ? te_ff :
                       (addr_s == ddchp_pkg::RD_SYNC_CNT)   ? sync_cnt_ff : 8'h00;
  // data captured at falling read edge, held until strobe returns high [R6] [R3]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_ff <= 8'h00;
      rd_oe_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (rd_fall) rdata_ff <= rd_mux;
      if (rd_fall) rd_oe_ff <= 1'b1;
      else if (~rd_s) rd_oe_ff <= 1'b0;
    end
  end
  assign BUS.dev_data_to_host = rdata_ff;
  assign BUS.dev_data_oe      = rd_oe_ff;
  // ---------------------------------------------------------------
  // serial output: divided bit clock, frame strobe, shift data
  // ---------------------------------------------------------------
  logic [7:0] div_cnt_ff;
  logic       sclk_ff;
  logic [2:0] bit_ff;
  logic [7:0] sh_ff;
  logic       frame_ff;
  wire        div_hit = (div_cnt_ff >= div_w);
  // half period of div ratio plus one processing cycles; zero gives one cycle [R1]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_cnt_ff <= 8'h00;
      sclk_ff    <= 1'b0;
      bit_ff     <= 3'h0;
      sh_ff      <= 8'h00;
      frame_ff   <= 1'b0;
    end else if (CLK_EN) begin
      div_cnt_ff <= div_hit ? 8'h00 : div_cnt_ff + 8'h01;
      if (div_hit) begin
        sclk_ff <= ~sclk_ff;  // [R1]
        if (sclk_ff) begin    // data changes on falling bit clock
          frame_ff <= (bit_ff == 3'h7);  // [R17]
          bit_ff   <= bit_ff + 3'h1;
          sh_ff    <= (bit_ff == 3'h7) ? cw_ff[ddchp_pkg::CW_SER_WORD] : {sh_ff[6:0], 1'b0};
        end
      end
    end
  end
  assign BUS.serial_bit_clock    = sclk_ff;
  assign BUS.serial_frame_strobe = frame_ff;
  assign BUS.serial_data_out_a   = sh_ff[7];
  assign BUS.serial_data_out_b   = sh_ff[0];
  assign BUS.serial_out_oe       = ~ser_dis;  // [R2]
endmodule

// File: verilog/ddchp_pkg.sv
// ddchp_pkg: shared constants for the downconverter host and sync port
// assumes: the device end and the checker use these names by package::name
package ddchp_pkg;
  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  // ---------------------------------------------------------------
  // control word slots (address selects one of eight)
  // ---------------------------------------------------------------
  localparam logic [2:0] CW_SYNC_SEL   = 3'h0; // front sync targets, sync out source
  localparam logic [2:0] CW_BACK_EN_A  = 3'h1; // fir sync enable
  localparam logic [2:0] CW_BACK_EN_B  = 3'h2; // timing nco sync enable
  localparam logic [2:0] CW_BACK_EN_C  = 3'h3; // agc sync enable
  localparam logic [2:0] CW_SER_DIV    = 3'h4; // serial bit clock divide ratio
  localparam logic [2:0] CW_SYNC_CMD   = 3'h5; // write fires sync strobe
  localparam logic [2:0] CW_SER_WORD   = 3'h6; // serial test word
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SEL_CIC_BIT   = 0;
  localparam int SEL_NCO_BIT   = 1;
  localparam int SEL_SRC_BIT   = 2; // 1: sample clock timed strobe
  localparam int EN_BIT        = 0;
  // ---------------------------------------------------------------
  // read locations
  // ---------------------------------------------------------------
  localparam logic [2:0] RD_STATUS     = 3'h0;
  localparam logic [2:0] RD_TIMING_ERR = 3'h1;
  localparam logic [2:0] RD_SYNC_CNT   = 3'h2;
  // ---------------------------------------------------------------
  // reset values and serial word length
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CW        = 8'h00;
  localparam logic [7:0] RST_DIV       = 8'h01;
  localparam int SER_WORD_BITS = 8;
endpackage

// File: verilog/ddchp_if.sv
// ddchp_if: host strobed byte port plus serial and sync pins
// assumes: testbench resolves the data bus from the two enables
`timescale 1ns/10ps
interface ddchp_if;
  logic [7:0] host_data_to_dev;
  logic [7:0] host_data_from_dev;
  logic       host_data_oe;
  logic [7:0] dev_data_to_host;
  logic       dev_data_oe;
  logic [2:0] addr;
  logic       wr_n;
  logic       rd_n;
  logic       serial_data_out_a;
  logic       serial_data_out_b;
  logic       serial_bit_clock;
  logic       serial_frame_strobe;
  logic       serial_out_oe;
  logic       serial_output_disable;
  logic       sync_strobe_out;
  logic       front_sync_in;
  logic       back_sync_in;
  modport device (
    input  host_data_to_dev, addr, wr_n, rd_n, serial_output_disable, front_sync_in, back_sync_in,
    output dev_data_to_host, dev_data_oe, serial_data_out_a, serial_data_out_b, serial_bit_clock,
           serial_frame_strobe, serial_out_oe, sync_strobe_out
  );
  modport host (
    input  dev_data_to_host, dev_data_oe, serial_data_out_a, serial_data_out_b, serial_bit_clock,
           serial_frame_strobe, serial_out_oe, sync_strobe_out,
    output host_data_from_dev, host_data_oe, addr, wr_n, rd_n, serial_output_disable,
           front_sync_in, back_sync_in
  );
endinterface

// File: verilog/ddchp_sync2.sv
// ddchp_sync2: two flip-flop level synchroniser
// assumes: d comes from another clock domain or a pin
`timescale 1ns/10ps
module ddchp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  // ---------------------------------------------------------------
  // two stages; first stage read only by the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// File: verilog/ddchp_host.sv
// ddchp_host: processor end issuing strobed byte writes and reads
// assumes: software port on REF_CLK; bus pins decoded from flops, sync and disable pins passed straight through
`timescale 1ns/10ps
module ddchp_host #(
  parameter int PHASE = 4  // clocks per strobe phase
) (
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CLK_EN,
  ddchp_if.host           BUS,
  input  wire logic [3:0] SW_ADDR,
  input  wire logic [7:0] SW_WDATA,
  input  wire logic       SW_WR,
  input  wire logic       SW_RD,
  output logic      [7:0] SW_RDATA,
  input  wire logic       FRONT_SYNC,
  input  wire logic       BACK_SYNC,
  input  wire logic       SER_DISABLE
);
  typedef enum {IDLE, SETUP, STROBE, HOLD} ddchp_st_t;
  ddchp_st_t st_ff;
  logic [7:0] cnt_ff;
  logic       is_rd_ff;
  logic [7:0] dev_data_s;
  logic [7:0] last_rd_ff;
  logic [7:0] rdata_ff;
  logic [2:0] addr_ff;
  logic [7:0] wdata_ff;
  wire        busy  = (st_ff != IDLE);
  wire        phase_done = (cnt_ff == 8'(PHASE - 1));
  ddchp_sync2 #(.W(8)) u_rd (.clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN),
    .d(BUS.dev_data_to_host), .q(dev_data_s));
  // ---------------------------------------------------------------
  // strobe sequencer: setup, strobe low, hold with data stable [R5] [R6]
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff      <= IDLE;
      cnt_ff     <= 8'h00;
      is_rd_ff   <= 1'b0;
      addr_ff    <= 3'h0;
      wdata_ff   <= 8'h00;
      last_rd_ff <= 8'h00;
    end else if (CLK_EN) begin
      cnt_ff <= phase_done ? 8'h00 : cnt_ff + 8'h01;
      case (st_ff)
        IDLE: begin
          cnt_ff <= 8'h00;
          // status reads at address 8 stay local and start no bus cycle
          if (SW_WR | (SW_RD & ~SW_ADDR[3])) begin
            st_ff    <= SETUP;
            is_rd_ff <= SW_RD;
            addr_ff  <= SW_ADDR[2:0];  // [R4]
            wdata_ff <= SW_WDATA;      // [R3]
          end
        end
        SETUP:  if (phase_done) st_ff <= STROBE;
        STROBE: if (phase_done) st_ff <= HOLD;
        HOLD: begin
          if (phase_done) begin
            st_ff <= IDLE;
            if (is_rd_ff) last_rd_ff <= dev_data_s;
          end
        end
        default: st_ff <= IDLE;
      endcase
    end
  end
  // software status at address 8: busy flag; else last read byte
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) rdata_ff <= 8'h00;
    else if (CLK_EN && SW_RD) rdata_ff <= SW_ADDR[3] ? {7'h00, busy} : last_rd_ff;
  end
  assign SW_RDATA = rdata_ff;
  assign BUS.addr = addr_ff;
  assign BUS.wr_n = ~((st_ff == STROBE) & ~is_rd_ff);
  assign BUS.rd_n = ~(((st_ff == STROBE) | (st_ff == HOLD)) & is_rd_ff);
  assign BUS.host_data_from_dev = wdata_ff;
  assign BUS.host_data_oe = busy & ~is_rd_ff;  // held through rising write edge [R5]
  assign BUS.front_sync_in = FRONT_SYNC;
  assign BUS.back_sync_in  = BACK_SYNC;
  assign BUS.serial_output_disable = SER_DISABLE;
endmodule

// File: testbench/ddchp_checker.sv
// ddchp_checker: concurrent checks on the host byte port, serial pins and sync strobe
// assumes: instantiated beside the interface, all signals on the processing clock
`timescale 1ns/10ps
module ddchp_checker (
  input wire logic       REF_CLK,
  input wire logic       SYS_RST,
  input wire logic [7:0] host_data_from_dev,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe,
  input wire logic [2:0] addr,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       serial_out_oe,
  input wire logic       serial_output_disable,
  input wire logic       sync_strobe_out
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  // ---------------------------------------------------------------
  // host strobes and data bus
  // ---------------------------------------------------------------
  bus_owner_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("data bus driven by both ends");
  strobe_excl_a: assert property (wr_n || rd_n)
    else $error("read and write strobes low together");
  wr_low_a: assert property ($fell(wr_n) |-> (!wr_n) [*3])
    else $error("write strobe low too briefly");
  wr_hold_a: assert property ((!wr_n || $rose(wr_n)) |-> host_data_oe && $stable(addr) && $stable(host_data_from_dev))
    else $error("address or data moved around the write edge");
  rd_answer_a: assert property ($fell(rd_n) |-> ##[2:6] dev_data_oe)
    else $error("read strobe got no answer on the bus");
  rd_owner_a: assert property ($rose(dev_data_oe) |-> !rd_n)
    else $error("device drove bus without a read strobe");
  rd_release_a: assert property (rd_n [*6] |-> !dev_data_oe)
    else $error("device kept the bus after the read");
  // ---------------------------------------------------------------
  // serial tri-state and sync strobe
  // ---------------------------------------------------------------
  ser_float_a: assert property (serial_output_disable [*6] |-> !serial_out_oe)
    else $error("serial pins driven while disabled");
  ser_drive_a: assert property (!serial_output_disable [*6] |-> serial_out_oe)
    else $error("serial pins floating while enabled");
  sync_pulse_a: assert property ($rose(sync_strobe_out) |=> !sync_strobe_out)
    else $error("sync strobe longer than one cycle");
  sync_cmd_a: assert property ($rose(wr_n) && addr == ddchp_pkg::CW_SYNC_CMD |-> ##[1:16] sync_strobe_out)
    else $error("sync command gave no strobe");
endmodule

// File: testbench/test_downconverter_host_sync_port.sv
// test_downconverter_host_sync_port: self-checking bench for host and device ends
// assumes: ends joined by ddchp_if; the bench resolves the shared data bus
`timescale 1ns/10ps
module test_downconverter_host_sync_port;
  localparam int PH = 6;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic       sw_wr = 1'b0;
  logic       sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic       front_sync = 1'b0;
  logic       back_sync = 1'b0;
  logic       ser_disable = 1'b0;
  logic       sample_clk = 1'b0;
  logic       tref_clk = 1'b0;
  logic       chip_sync;
  logic       cic_s, nco_s, fir_s, tnco_s, agc_s;
  logic [4:0] seen = 5'h00;
  logic [1:0] pulses = 2'h0;
  logic       clr = 1'b0;
  logic       snap = 1'b0;
  logic       rd_d = 1'b0;
  logic [1:0] oe_sh = 2'h0;
  logic       sclk_d = 1'b0;
  logic       ser_arm = 1'b0;
  logic [7:0] shreg = 8'h00;
  logic [4:0] en;
  logic [7:0] word;
  int         bits_left = 0;
  int         half = 0;
  int         half_cnt = 0;
  int         div;
  int         miscompares = 0;
  int         tests_run = 0;
  logic [7:0] exp_q[$];
  logic [7:0] ser_q[$];
  ddchp_if bus_if ();
  // ---------------------------------------------------------------
  // clocks, bus resolution and the two ends
  // ---------------------------------------------------------------
  always #2.5 ref_clk = ~ref_clk;
  always #11.5 sample_clk = ~sample_clk;
  always #8.5 tref_clk = ~tref_clk;
  // undriven bus shows the inverse so a stale value never passes
  assign bus_if.host_data_to_dev = bus_if.host_data_oe ? bus_if.host_data_from_dev :
                                   bus_if.dev_data_oe ? bus_if.dev_data_to_host : ~bus_if.host_data_from_dev;
  ddchp_host #(.PHASE(PH)) ddchp_host_i (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .BUS(bus_if.host), .SW_ADDR(sw_addr),
    .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .FRONT_SYNC(front_sync),
    .BACK_SYNC(back_sync), .SER_DISABLE(ser_disable)
  );
  ddchp_device ddchp_device_i (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .BUS(bus_if.device), .FRONTEND_SAMPLE_CLOCK(sample_clk),
    .TIMING_REFERENCE_CLOCK(tref_clk), .CHIP_SYNC_IN(chip_sync), .CHIP_SYNC_OUT(chip_sync),
    .CIC_SYNC(cic_s), .CARRIER_NCO_SYNC(nco_s), .FIR_SYNC(fir_s), .TIMING_NCO_SYNC(tnco_s), .AGC_SYNC(agc_s)
  );
  ddchp_checker ddchp_checker_i (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .host_data_from_dev(bus_if.host_data_from_dev),
    .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe), .addr(bus_if.addr), .wr_n(bus_if.wr_n),
    .rd_n(bus_if.rd_n), .serial_out_oe(bus_if.serial_out_oe), .serial_output_disable(bus_if.serial_output_disable),
    .sync_strobe_out(bus_if.sync_strobe_out)
  );
  // ---------------------------------------------------------------
  // checking and result watching
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen_v, input logic [7:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp_v, seen_v);
    end
  endtask
  // sticky record of sync levels and strobe pulses, so short pulses are not missed
  always @(posedge ref_clk) begin
    seen <= clr ? 5'h00 : seen | {cic_s, nco_s, fir_s, tnco_s, agc_s};
    pulses <= clr ? 2'h0 : pulses + {1'b0, bus_if.sync_strobe_out};
  end
  // each result takes the oldest note; bus data is taken in its second driven cycle
  always @(posedge ref_clk) begin
    oe_sh <= {oe_sh[0], bus_if.dev_data_oe};
    rd_d <= sw_rd && sw_addr == 4'h8;
    if (bus_if.dev_data_oe && oe_sh == 2'h1) check("read data", bus_if.dev_data_to_host, exp_q.pop_front());
    if (rd_d) check("host status", sw_rdata & 8'h01, exp_q.pop_front());
    if (snap) check("sync snapshot", {seen, bus_if.serial_out_oe, pulses}, exp_q.pop_front());
    sclk_d <= bus_if.serial_bit_clock;
    half_cnt <= (bus_if.serial_bit_clock != sclk_d) ? 1 : half_cnt + 1;
    if (bus_if.serial_bit_clock != sclk_d) half <= half_cnt;
    if (bus_if.serial_bit_clock && !sclk_d && ser_arm) begin
      if (bits_left > 0) begin
        shreg <= {shreg[6:0], bus_if.serial_data_out_a};
        bits_left <= bits_left - 1;
        if (bits_left == 1) begin
          check("serial word", {shreg[6:0], bus_if.serial_data_out_a}, ser_q.pop_front());
          check("serial half period", 8'(half), ser_q.pop_front());
          ser_arm <= 1'b0;
        end
      end else if (bus_if.serial_frame_strobe) begin
        shreg <= {shreg[6:0], bus_if.serial_data_out_a};  // msb stands beside the frame strobe
        bits_left <= 7;
        check("serial lsb on b", {7'h00, bus_if.serial_data_out_b}, ser_q.pop_front());
      end
    end
  end
  // ---------------------------------------------------------------
  // software port drivers
  // ---------------------------------------------------------------
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d, input int n = 1);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    repeat (n) @(posedge ref_clk);
    sw_wr <= 1'b0;
    repeat (3 * PH + 2) @(posedge ref_clk);
  endtask
  task automatic sw_read(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    repeat (3 * PH + 2) @(posedge ref_clk);
  endtask
  task automatic take_snap(input logic [7:0] e, input int wait_n);
    repeat (wait_n) @(posedge ref_clk);
    exp_q.push_back(e);
    snap <= 1'b1;
    @(posedge ref_clk);
    snap <= 1'b0;
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hD0C5));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    sw_read(4'h8, 8'h00);
    for (int a = 3; a < 8; a++) sw_read(4'(a), 8'h00);
    // every mix of front and back sync targets; third snap proves the levels drop
    for (int i = 0; i < 32; i++) begin
      en = 5'(i);
      sw_write({1'b0, ddchp_pkg::CW_SYNC_SEL}, {6'h00, en[3], en[4]});
      sw_write({1'b0, ddchp_pkg::CW_BACK_EN_A}, {7'h00, en[2]});
      sw_write({1'b0, ddchp_pkg::CW_BACK_EN_B}, {7'h00, en[1]});
      sw_write({1'b0, ddchp_pkg::CW_BACK_EN_C}, {7'h00, en[0]});
      take_snap({5'h00, 1'b1, 2'h0}, 1);
      front_sync <= 1'b1;
      back_sync <= 1'b1;
      repeat (24) @(posedge ref_clk);
      front_sync <= 1'b0;
      back_sync <= 1'b0;
      take_snap({en, 1'b1, 2'h0}, 8);
      take_snap({5'h00, 1'b1, 2'h0}, 8);
    end
    // held command is a second request while busy and must give one strobe only
    for (int s = 0; s < 2; s++) begin
      sw_write({1'b0, ddchp_pkg::CW_SYNC_SEL}, 8'(s << ddchp_pkg::SEL_SRC_BIT));
      take_snap({5'h00, 1'b1, 2'h0}, 1);
      sw_write({1'b0, ddchp_pkg::CW_SYNC_CMD}, 8'h00, 2);
      take_snap({5'h00, 1'b1, 2'h1}, 20);
    end
    // random divider and word; half period is divider plus one
    for (int k = 0; k < 3; k++) begin
      div = int'($urandom_range(0, 3));
      word = 8'($urandom);
      sw_write({1'b0, ddchp_pkg::CW_SER_DIV}, 8'(div));
      ser_q.push_back({7'h00, word[0]});
      ser_q.push_back(word);
      ser_q.push_back(8'(div + 1));
      sw_write({1'b0, ddchp_pkg::CW_SER_WORD}, word);
      ser_arm <= 1'b1;  // armed only once the new word has landed
      repeat (200) @(posedge ref_clk);
    end
    check("serial frames left", 8'(ser_q.size()), 8'h00);
    ser_disable <= 1'b1;
    take_snap(8'h00, 12);
    ser_disable <= 1'b0;
    repeat (12) @(posedge ref_clk);
    check("results left", 8'(exp_q.size()), 8'h00);
    summarize();
  end
  // hang guard, well past the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
endmodule
